// File: src/dcspi_slave.sv
`timescale 1ns/100ps

// Operation
// - Four-wire full duplex serial slave port.
// - Select fall starts, select rise ends frame.
// - Capture on clock fall, launch on rise.
// - Select high: ignore pins, output released.
// - Select fall loads response into shifter.
// - Select fall drives error OR input level.
// - Sleep keeps output released, no transfer.
// - Valid length: sixteen plus nonzero eights.
// - Bad length sets error, drops command.
// - Valid end hands shifter word out.
// - Most significant bit first both ways.
// - Control bits lead, data bits follow.
// - Sixteen-bit shifter, one bit per clock.

module dcspi_slave
  import dcspi_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic chip_select_n,
  input wire logic sclk,
  input wire logic si,
  input wire logic sleep_mode,
  input wire logic [DCSPI_WORD_W-1:0] response_word,
  input wire logic ter_clear,
  output logic so_out,
  output logic so_oe,
  output logic [DCSPI_WORD_W-1:0] cmd_word,
  output logic cmd_strobe,
  output logic transfer_error_flag,
  output logic frame_active
);

  dcspi_pins_if pins();

  dcspi_state_type state_q;
  dcspi_state_type state_d;
  logic [DCSPI_WORD_W-1:0] shreg_q;
  logic [DCSPI_WORD_W-1:0] shreg_d;
  logic [DCSPI_CNT_W-1:0] cnt_q;
  logic [DCSPI_CNT_W-1:0] cnt_d;
  logic more_q;
  logic more_d;
  logic bad_q;
  logic bad_d;
  logic so_q;
  logic so_d;
  logic oe_q;
  logic oe_d;
  logic [DCSPI_WORD_W-1:0] cmd_q;
  logic [DCSPI_WORD_W-1:0] cmd_d;
  logic strobe_q;
  logic strobe_d;
  logic ter_q;
  logic ter_d;
  logic start;
  logic ok;

  // Length is good when only whole groups, at least one, followed the base pulses.
  function automatic logic frame_ok
  (
    input logic [DCSPI_CNT_W-1:0] cnt,
    input logic more
  );
    frame_ok = more && (cnt == DCSPI_CNT_BASE);
  endfunction : frame_ok

  // Pin synchronisers and edge finders.
  dcspi_sync u_sync
  (
    .clk(clk),
    .nrst(nrst),
    .chip_select_n(chip_select_n),
    .sclk(sclk),
    .si(si),
    .pins(pins)
  );

  assign start = (state_q == DCSPI_IDLE) && pins.cs_fall && !sleep_mode;
  assign ok = frame_ok(cnt_q, more_q) && !bad_q;

  always_comb
  begin
    state_d = state_q;
    shreg_d = shreg_q;
    cnt_d = cnt_q;
    more_d = more_q;
    bad_d = bad_q;
    so_d = so_q;
    oe_d = oe_q;
    cmd_d = cmd_q;
    strobe_d = 1'b0;
    ter_d = ter_q;
    if (ter_clear)
    begin
      ter_d = 1'b0;
    end
    case (state_q)
      DCSPI_IDLE:
      begin
        oe_d = 1'b0;
        if (start)
        begin
          state_d = DCSPI_SHIFT;
          shreg_d = response_word;
          cnt_d = DCSPI_CNT_RESET;
          more_d = 1'b0;
          bad_d = pins.sclk_lvl;
          oe_d = 1'b1;
          so_d = ter_q | pins.si_lvl;
        end
      end
      DCSPI_SHIFT:
      begin
        if (sleep_mode)
        begin
          state_d = DCSPI_IDLE;
          oe_d = 1'b0;
        end
        else if (pins.cs_rise)
        begin
          state_d = DCSPI_CHECK;
          oe_d = 1'b0;
          bad_d = bad_q | pins.sclk_lvl;
        end
        else
        begin
          if (pins.sclk_rise)
          begin
            so_d = shreg_q[DCSPI_WORD_W-1];
          end
          if (pins.sclk_fall)
          begin
            shreg_d = {shreg_q[DCSPI_WORD_W-2:0], pins.si_lvl};
            if (cnt_q == DCSPI_CNT_LAST)
            begin
              cnt_d = DCSPI_CNT_BASE;
              more_d = 1'b1;
            end
            else
            begin
              cnt_d = cnt_q + 5'h01;
            end
          end
        end
      end
      DCSPI_CHECK:
      begin
        state_d = DCSPI_IDLE;
        if (ok)
        begin
          cmd_d = shreg_q;
          strobe_d = 1'b1;
        end
        else
        begin
          ter_d = 1'b1;
        end
      end
      default:
      begin
        state_d = DCSPI_IDLE;
        oe_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= DCSPI_IDLE;
      shreg_q <= DCSPI_WORD_RESET;
      cnt_q <= DCSPI_CNT_RESET;
      more_q <= 1'b0;
      bad_q <= 1'b0;
      so_q <= 1'b0;
      oe_q <= 1'b0;
      cmd_q <= DCSPI_WORD_RESET;
      strobe_q <= 1'b0;
      ter_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      shreg_q <= shreg_d;
      cnt_q <= cnt_d;
      more_q <= more_d;
      bad_q <= bad_d;
      so_q <= so_d;
      oe_q <= oe_d;
      cmd_q <= cmd_d;
      strobe_q <= strobe_d;
      ter_q <= ter_d;
    end
  end

  assign so_out = so_q;
  assign so_oe = oe_q;
  assign cmd_word = cmd_q;
  assign cmd_strobe = strobe_q;
  assign transfer_error_flag = ter_q;
  assign frame_active = (state_q == DCSPI_SHIFT);

  // The output is driven exactly while a frame is being shifted.
  property p_oe_frame;
    @(posedge clk) disable iff (!nrst)
      so_oe == (state_q == DCSPI_SHIFT);
  endproperty
  a_oe_frame: assert property (p_oe_frame)
    else $error("Output enable does not follow the frame.");

  // The output is released once the select is seen high.
  property p_select_high;
    @(posedge clk) disable iff (!nrst)
      so_oe |-> !pins.cs_n || pins.cs_rise;
  endproperty
  a_select_high: assert property (p_select_high)
    else $error("Output driven while select is high.");

  // A select fall starts driving the error flag OR the input level.
  property p_start_out;
    @(posedge clk) disable iff (!nrst)
      start |=> so_oe && (so_out == $past(ter_q | pins.si_lvl));
  endproperty
  a_start_out: assert property (p_start_out)
    else $error("Wrong first output level after select fall.");

  // A select fall loads the response word and clears the counter.
  property p_start_load;
    @(posedge clk) disable iff (!nrst)
      start |=> (shreg_q == $past(response_word))
        && (cnt_q == DCSPI_CNT_RESET)
        && !more_q;
  endproperty
  a_start_load: assert property (p_start_load)
    else $error("Shifter or counter not set up at select fall.");

  // In sleep the output is released and no frame starts.
  property p_sleep;
    @(posedge clk) disable iff (!nrst)
      sleep_mode |=> !so_oe && (state_q != DCSPI_SHIFT);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("Transfer active during sleep.");

  // A rising shift clock launches the shifter's top bit.
  property p_launch;
    @(posedge clk) disable iff (!nrst)
      (frame_active && pins.sclk_rise && !pins.cs_rise && !sleep_mode)
        |=> (so_out == $past(shreg_q[DCSPI_WORD_W-1]));
  endproperty
  a_launch: assert property (p_launch)
    else $error("Output bit not launched from the top of the shifter.");

  // A falling shift clock moves the input bit into the bottom.
  property p_capture;
    @(posedge clk) disable iff (!nrst)
      (frame_active && pins.sclk_fall && !pins.cs_rise && !sleep_mode)
        |=> (shreg_q == {$past(shreg_q[DCSPI_WORD_W-2:0]),
          $past(pins.si_lvl)});
  endproperty
  a_capture: assert property (p_capture)
    else $error("Input bit not captured at the bottom of the shifter.");

  // A select rise ends the frame with one check cycle.
  property p_end;
    @(posedge clk) disable iff (!nrst)
      (frame_active && pins.cs_rise && !sleep_mode)
        |=> (state_q == DCSPI_CHECK) ##1 (state_q == DCSPI_IDLE);
  endproperty
  a_end: assert property (p_end)
    else $error("Frame did not end after select rise.");

  // A good frame hands the shifter word out as one pulse.
  property p_cmd;
    @(posedge clk) disable iff (!nrst)
      (state_q == DCSPI_CHECK && ok)
        |=> cmd_strobe && (cmd_word == $past(shreg_q)) ##1 !cmd_strobe;
  endproperty
  a_cmd: assert property (p_cmd)
    else $error("Good frame not handed out.");

  // A bad frame raises the error flag and hands nothing out.
  property p_err;
    @(posedge clk) disable iff (!nrst)
      (state_q == DCSPI_CHECK && !ok)
        |=> transfer_error_flag && !cmd_strobe;
  endproperty
  a_err: assert property (p_err)
    else $error("Bad frame did not raise the error flag.");

  // Commands only leave after a length of sixteen plus eights.
  property p_len;
    @(posedge clk) disable iff (!nrst)
      $rose(cmd_strobe) |-> $past(more_q)
        && ($past(cnt_q) == DCSPI_CNT_BASE);
  endproperty
  a_len: assert property (p_len)
    else $error("Command taken with a wrong frame length.");

endmodule : dcspi_slave

// File: src/dcspi_pkg.sv
package dcspi_pkg;

  // Shift register width and frame length checking.
  localparam int DCSPI_WORD_W = 16;
  localparam int DCSPI_FRAME_BASE = 16;
  localparam int DCSPI_GROUP = 8;
  localparam int DCSPI_CNT_W = 5;
  localparam logic [DCSPI_CNT_W-1:0] DCSPI_CNT_BASE = 5'h10;
  localparam logic [DCSPI_CNT_W-1:0] DCSPI_CNT_LAST = 5'h17;
  localparam logic [DCSPI_CNT_W-1:0] DCSPI_CNT_RESET = 5'h00;

  // Reset values of the word registers.
  localparam logic [DCSPI_WORD_W-1:0] DCSPI_WORD_RESET = 16'h0000;

  // Pin vector layout: select, shift clock, serial input.
  localparam int DCSPI_PIN_W = 3;
  localparam int DCSPI_PIN_CS = 2;
  localparam int DCSPI_PIN_SCLK = 1;
  localparam int DCSPI_PIN_SI = 0;
  localparam logic [DCSPI_PIN_W-1:0] DCSPI_PIN_RESET = 3'h4;

  // Port control states, Gray coded along the frame.
  typedef enum logic [1:0]
  {
    DCSPI_IDLE = 2'h0,
    DCSPI_SHIFT = 2'h1,
    DCSPI_CHECK = 2'h3
  } dcspi_state_type;

endpackage : dcspi_pkg

// File: src/dcspi_pins_if.sv
`timescale 1ns/100ps

interface dcspi_pins_if;
  logic cs_n;
  logic sclk_lvl;
  logic si_lvl;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;

  modport src
  (
    output cs_n,
    output sclk_lvl,
    output si_lvl,
    output cs_fall,
    output cs_rise,
    output sclk_rise,
    output sclk_fall
  );

  modport dst
  (
    input cs_n,
    input sclk_lvl,
    input si_lvl,
    input cs_fall,
    input cs_rise,
    input sclk_rise,
    input sclk_fall
  );
endinterface : dcspi_pins_if

// File: src/dcspi_sync.sv
`timescale 1ns/100ps

module dcspi_sync
  import dcspi_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic chip_select_n,
  input wire logic sclk,
  input wire logic si,
  dcspi_pins_if.src pins
);

  logic [DCSPI_PIN_W-1:0] meta_q;
  logic [DCSPI_PIN_W-1:0] meta_d;
  logic [DCSPI_PIN_W-1:0] sync_q;
  logic [DCSPI_PIN_W-1:0] sync_d;
  logic [DCSPI_PIN_W-1:0] prev_q;
  logic [DCSPI_PIN_W-1:0] prev_d;

  // Two stages per pin, then one more stage for edge finding.
  always_comb
  begin
    meta_d = {chip_select_n, sclk, si};
    sync_d = meta_q;
    prev_d = sync_q;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_q <= DCSPI_PIN_RESET;
      sync_q <= DCSPI_PIN_RESET;
      prev_q <= DCSPI_PIN_RESET;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  assign pins.cs_n = sync_q[DCSPI_PIN_CS];
  assign pins.sclk_lvl = sync_q[DCSPI_PIN_SCLK];
  assign pins.si_lvl = sync_q[DCSPI_PIN_SI];
  assign pins.cs_fall = prev_q[DCSPI_PIN_CS] & ~sync_q[DCSPI_PIN_CS];
  assign pins.cs_rise = ~prev_q[DCSPI_PIN_CS] & sync_q[DCSPI_PIN_CS];
  assign pins.sclk_rise = ~prev_q[DCSPI_PIN_SCLK] & sync_q[DCSPI_PIN_SCLK];
  assign pins.sclk_fall = prev_q[DCSPI_PIN_SCLK] & ~sync_q[DCSPI_PIN_SCLK];

endmodule : dcspi_sync

// File: testbench/dcspi_master.sv
`timescale 1ns/100ps

module dcspi_master
(
  input wire logic clk,
  input wire logic so_out,
  input wire logic so_oe,
  input wire logic cmd_strobe,
  output logic chip_select_n,
  output logic sclk,
  output logic si
);
  // Select idles high and the shift clock idles low.
  initial
  begin
    chip_select_n = 1'h1;
    sclk = 1'h0;
    si = 1'h0;
  end

  // One frame of n bits, most significant first, 160 ns clock period.
  task automatic xfer(input int n, input logic [63:0] tx,
    output logic [63:0] rx, output logic first, output int oe_n,
    output int st);
    logic line;
    line = 1'h0;
    rx = 64'h0;
    oe_n = 0;
    st = 0;
    @(negedge clk);
    si = tx[n-1];
    @(negedge clk);
    chip_select_n = 1'h0;
    repeat (10) @(negedge clk);
    line = so_oe ? so_out : ~line;
    first = line;
    for (int i = n - 1; i >= 0; i--)
    begin
      sclk = 1'h1;
      si = tx[i];
      repeat (4) @(negedge clk);
      sclk = 1'h0;
      repeat (3) @(negedge clk);
      line = so_oe ? so_out : ~line;
      rx[i] = line;
      oe_n += so_oe;
      @(negedge clk);
    end
    repeat (9) @(negedge clk);
    chip_select_n = 1'h1;
    repeat (14)
    begin
      @(negedge clk);
      st += cmd_strobe;
    end
  endtask : xfer

  // Frame whose select edges both come while the shift clock is high.
  task automatic xfer_hi(input int n, output int st);
    st = 0;
    @(negedge clk);
    sclk = 1'h1;
    repeat (4) @(negedge clk);
    chip_select_n = 1'h0;
    repeat (10) @(negedge clk);
    for (int i = 0; i < n; i++)
    begin
      sclk = 1'h0;
      repeat (4) @(negedge clk);
      sclk = 1'h1;
      repeat (4) @(negedge clk);
    end
    chip_select_n = 1'h1;
    repeat (4) @(negedge clk);
    sclk = 1'h0;
    repeat (14)
    begin
      @(negedge clk);
      st += cmd_strobe;
    end
  endtask : xfer_hi

  // Clock and data activity with select held high.
  task automatic wiggle(output int oe_n, output int st);
    oe_n = 0;
    st = 0;
    repeat (16)
    begin
      @(negedge clk);
      sclk = ~sclk;
      si = ~si;
      repeat (4)
      begin
        @(negedge clk);
        oe_n += so_oe;
        st += cmd_strobe;
      end
    end
  endtask : wiggle
endmodule : dcspi_master

// File: testbench/daisy_chain_spi_slave_tb.sv
`timescale 1ns/100ps

module daisy_chain_spi_slave_tb
  import dcspi_pkg::*;
;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic sleep_mode = 1'h0;
  logic ter_clear = 1'h0;
  logic [DCSPI_WORD_W-1:0] response_word = 16'h0000;
  logic chip_select_n;
  logic sclk;
  logic si;
  logic so_out;
  logic so_oe;
  logic cmd_strobe;
  logic transfer_error_flag;
  logic frame_active;
  logic [DCSPI_WORD_W-1:0] cmd_word;
  int err_count = 0;
  int compares = 0;
  logic [63:0] rx;
  logic first;
  int oe_n;
  int st;

  always #10 clk = ~clk;

  dcspi_slave uut
  (
    .clk(clk),
    .nrst(nrst),
    .chip_select_n(chip_select_n),
    .sclk(sclk),
    .si(si),
    .sleep_mode(sleep_mode),
    .response_word(response_word),
    .ter_clear(ter_clear),
    .so_out(so_out),
    .so_oe(so_oe),
    .cmd_word(cmd_word),
    .cmd_strobe(cmd_strobe),
    .transfer_error_flag(transfer_error_flag),
    .frame_active(frame_active)
  );

  dcspi_master partner
  (
    .clk(clk),
    .so_out(so_out),
    .so_oe(so_oe),
    .cmd_strobe(cmd_strobe),
    .chip_select_n(chip_select_n),
    .sclk(sclk),
    .si(si)
  );

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  // Valid frame of n bits: response out first, then input passed through.
  task automatic t_valid(input int n, input logic [63:0] tx,
    input logic [15:0] resp);
    logic [63:0] exp;
    @(negedge clk);
    response_word = resp;
    exp = ({48'h0, resp} << (n - 16)) | (tx >> 16);
    partner.xfer(n, tx, rx, first, oe_n, st);
    check(rx, exp);
    check(first, tx[n-1]);
    check(oe_n, n);
    check(st, 1);
    check(cmd_word, tx[15:0]);
    check({so_oe, frame_active, transfer_error_flag}, 3'h0);
    $display("test valid %0d done", n);
  endtask : t_valid

  // Bad length sets the flag, which then leads the next frame.
  task automatic t_bad(input int n);
    logic [15:0] old;
    old = cmd_word;
    partner.xfer(n, 64'hffff_ffff, rx, first, oe_n, st);
    check(st, 0);
    check(cmd_word, old);
    check(transfer_error_flag, 1'h1);
    partner.xfer(24, 64'h00_1234, rx, first, oe_n, st);
    check(first, 1'h1);
    check(st, 1);
    @(negedge clk);
    ter_clear = 1'h1;
    @(negedge clk);
    ter_clear = 1'h0;
    check(transfer_error_flag, 1'h0);
    $display("test bad %0d done", n);
  endtask : t_bad

  // Sleep blocks the frame and keeps the output released.
  task automatic t_sleep;
    logic [15:0] old;
    old = cmd_word;
    @(negedge clk);
    sleep_mode = 1'h1;
    partner.xfer(24, 64'h5a_5a5a, rx, first, oe_n, st);
    check(oe_n, 0);
    check(st, 0);
    check(cmd_word, old);
    sleep_mode = 1'h0;
    $display("test sleep done");
  endtask : t_sleep

  // Sleep in mid-frame aborts it without a command or an error.
  task automatic t_abort;
    logic [15:0] old;
    old = cmd_word;
    fork
      partner.xfer(24, 64'h3c_c3a5, rx, first, oe_n, st);
      begin
        repeat (60) @(negedge clk);
        sleep_mode = 1'h1;
      end
    join
    sleep_mode = 1'h0;
    check(oe_n, 6);
    check(st, 0);
    check(cmd_word, old);
    check({so_oe, frame_active, transfer_error_flag}, 3'h0);
    $display("test abort done");
  endtask : t_abort

  // Shift clock high at the select edges rejects the frame.
  task automatic t_clk_high;
    logic [15:0] old;
    old = cmd_word;
    partner.xfer_hi(24, st);
    check(st, 0);
    check(cmd_word, old);
    check(transfer_error_flag, 1'h1);
    @(negedge clk);
    ter_clear = 1'h1;
    @(negedge clk);
    ter_clear = 1'h0;
    check(transfer_error_flag, 1'h0);
    $display("test clock high done");
  endtask : t_clk_high

  // Pin activity with select high is ignored.
  task automatic t_ignore;
    partner.wiggle(oe_n, st);
    check(oe_n, 0);
    check(st, 0);
    check(frame_active, 1'h0);
    $display("test ignore done");
  endtask : t_ignore

  initial
  begin
    #1000000;
    err_count++;
    complete_run();
  end

  initial
  begin
    repeat (10) @(negedge clk);
    nrst = 1'h1;
    repeat (4) @(negedge clk);
    check({so_oe, transfer_error_flag, frame_active, cmd_word}, 0);
    t_ignore();
    t_valid(24, 64'h12_3456, 16'ha53c);
    t_valid(32, 64'h9abc_def0, 16'h8001);
    t_valid(40, 64'hc3_7e15_a9b2, 16'h7ffe);
    t_bad(16);
    t_bad(23);
    t_bad(25);
    t_sleep();
    t_abort();
    t_clk_high();
    t_valid(24, 64'h80_0001, 16'h0ff0);
    complete_run();
  end
endmodule : daisy_chain_spi_slave_tb
